// *** shared/sram_port_pkg.sv ***
// Purpose: Shared constants and types for the burst-of-two DDR SRAM port
// Assumes: One 20 MHz system clock; link clocks are derived from it
// Notes: One memory clock period spans two system clock cycles
package sram_port_pkg;

	// ************************************************************
	// Geometry of the wide variant
	// ************************************************************
	localparam int ADDR_W = 21;
	localparam int ROW_W = 20;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int CLK_PERIOD_NS = 50;

	// ************************************************************
	// Read pipeline and capture positions
	// ************************************************************
	localparam int PIPE_SLOTS = 4;
	localparam logic [1:0] SLOT_LEGACY = 2'h1;
	localparam logic [1:0] SLOT_DDR2 = 2'h2;
	localparam logic [2:0] ECHO_FIRST_LEGACY = 3'h2;
	localparam logic [2:0] ECHO_FIRST_DDR2 = 3'h3;

	// ************************************************************
	// Reset values and buffering
	// ************************************************************
	localparam logic [LANES-1:0] MASK_IDLE = 4'hF;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LEVEL_W = 4;
	localparam logic [FIFO_LEVEL_W-1:0] FIFO_ROOM_MAX = 4'h6;

	// ************************************************************
	// State encodings
	// ************************************************************
	typedef enum logic [2:0] {
		WR_IDLE = 3'h1,
		WR_BEAT0 = 3'h2,
		WR_BEAT1 = 3'h4
	} wr_state_t;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_CMD = 5'h02,
		H_WBEAT1 = 5'h04,
		H_WEND = 5'h08,
		H_RWAIT = 5'h10
	} host_state_t;

endpackage

// *** shared/sram_link_if.sv ***
// Purpose: Pin bundle between memory controller and SRAM port
// Assumes: Both ends run on the same system clock
// Notes: Shared data bus is resolved from the device output enable alone
`timescale 1ns/1ps
`default_nettype none
interface sram_link_if;
	import sram_port_pkg::*;

	// Clocks, control, address and masks from the controller
	logic k_p;
	logic k_n;
	logic c_p;
	logic c_n;
	logic cycle_load_n;
	logic rd_not_wr;
	logic [ADDR_W-2:0] addr_upper;
	logic burst_start_lsb;
	logic [LANES-1:0] byte_lane_mask_n;
	logic pll_disable_n;
	// Data bus, one driver pair per end
	logic [DATA_W-1:0] host_dq_out;
	logic host_dq_oe;
	logic [DATA_W-1:0] dev_dq_out;
	logic dev_dq_oe;
	logic [DATA_W-1:0] dq;
	// Echo clocks from the SRAM
	logic echo_clk_p;
	logic echo_clk_n;

	// Bus level; the device wins if both drive
	assign dq = dev_dq_oe ? dev_dq_out : host_dq_out;

	modport device (
		input k_p, k_n, c_p, c_n, cycle_load_n, rd_not_wr,
		input addr_upper, burst_start_lsb, byte_lane_mask_n,
		input pll_disable_n, dq,
		output dev_dq_out, dev_dq_oe, echo_clk_p, echo_clk_n
	);

	modport host (
		output k_p, k_n, c_p, c_n, cycle_load_n, rd_not_wr,
		output addr_upper, burst_start_lsb, byte_lane_mask_n,
		output pll_disable_n, host_dq_out, host_dq_oe,
		input dq, echo_clk_p, echo_clk_n
	);

endinterface
`default_nettype wire

// *** src/word_fifo.sv ***
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Level output lets the writer reserve room ahead
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in,
	// Fill level
	output logic [$clog2(DEPTH):0] level_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// Handshakes and flags
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign level_out = wr_ptr_reg - rd_ptr_reg;
	assign in_ready_out = level_out != (AW+1)'(DEPTH);
	assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
	assign out_data_out = mem[rd_ptr_reg[AW-1:0]];

	// Storage
	always_ff @(posedge clk_in)
	begin
		if (push)
		begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

	// Pointers
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// *** src/sram_device_end.sv ***
// Purpose: SRAM end of the burst-of-two DDR port, with its storage
// Assumes: Link clocks toggle on system clock edges; inputs synchronous
// Notes: C and C-bar both held high select single clock mode
`timescale 1ns/1ps
`default_nettype none
module sram_device_end (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Link to the controller
	sram_link_if.device link,
	// Status
	output logic single_clock_mode_out
);
	import sram_port_pkg::*;

	// ************************************************************
	// Clock edge detection
	// ************************************************************
	logic k_p_q;
	logic k_n_q;
	logic c_p_q;
	logic c_n_q;
	logic k_rise;
	logic kb_rise;
	logic single_mode;
	logic out_rise_p;
	logic out_rise_n;
	logic out_edge;

	// Previous levels of the link clocks
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			k_p_q <= 1'b1;
			k_n_q <= 1'b1;
			c_p_q <= 1'b1;
			c_n_q <= 1'b1;
		end
		else
		begin
			k_p_q <= link.k_p;
			k_n_q <= link.k_n;
			c_p_q <= link.c_p;
			c_n_q <= link.c_n;
		end
	end

	// Rising edges and output clock choice
	assign k_rise = link.k_p && !k_p_q;
	assign kb_rise = link.k_n && !k_n_q;
	assign single_mode = link.c_p && link.c_n;
	assign out_rise_p = single_mode ? k_rise : (link.c_p && !c_p_q);
	assign out_rise_n = single_mode ? kb_rise : (link.c_n && !c_n_q);
	assign out_edge = out_rise_p || out_rise_n;

	// ************************************************************
	// Command decode
	// ************************************************************
	logic cmd_go;
	logic rd_go;
	logic wr_go;
	logic [ROW_W-1:0] cmd_row;

	// Strobe and direction on the positive clock only
	assign cmd_go = k_rise && !link.cycle_load_n;
	assign rd_go = cmd_go && link.rd_not_wr;
	assign wr_go = cmd_go && !link.rd_not_wr;
	assign cmd_row = link.addr_upper;

	// ************************************************************
	// Write sequencing
	// ************************************************************
	wr_state_t wr_state_reg;
	logic [ROW_W-1:0] wr_row_reg;
	logic wr_lsb_reg;
	logic beat0_we;
	logic beat1_we;

	// Beat 0 on K-bar rise, beat 1 on the next K rise
	assign beat0_we = (wr_state_reg == WR_BEAT0) && kb_rise;
	assign beat1_we = (wr_state_reg == WR_BEAT1) && k_rise;

	// Write state
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			wr_state_reg <= WR_IDLE;
		end
		else
		begin
			case (wr_state_reg)
				WR_IDLE:
				begin
					if (wr_go)
					begin
						wr_state_reg <= WR_BEAT0;
					end
				end
				WR_BEAT0:
				begin
					if (kb_rise)
					begin
						wr_state_reg <= WR_BEAT1;
					end
				end
				WR_BEAT1:
				begin
					if (k_rise)
					begin
						wr_state_reg <= wr_go ? WR_BEAT0 : WR_IDLE;
					end
				end
				default:
				begin
					wr_state_reg <= WR_IDLE;
				end
			endcase
		end
	end

	// Address of the write burst
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			wr_row_reg <= '0;
			wr_lsb_reg <= 1'b0;
		end
		else if (wr_go)
		begin
			wr_row_reg <= cmd_row;
			wr_lsb_reg <= link.burst_start_lsb;
		end
	end

	// ************************************************************
	// Storage: two arrays, one slice per byte lane
	// ************************************************************
	logic [DATA_W-1:0] rd_word0;
	logic [DATA_W-1:0] rd_word1;

	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++)
		begin : g_lane
			logic [LANE_W-1:0] bank0 [2**ROW_W];
			logic [LANE_W-1:0] bank1 [2**ROW_W];
			logic [LANE_W-1:0] din;
			logic keep;

			assign din = link.dq[lane*LANE_W +: LANE_W];
			assign keep = link.byte_lane_mask_n[lane];

			// Masked lanes are simply not written
			always_ff @(posedge clk_in)
			begin
				if (beat0_we && !keep)
				begin
					if (wr_lsb_reg)
					begin
						bank1[wr_row_reg] <= din;
					end
					else
					begin
						bank0[wr_row_reg] <= din;
					end
				end
				else if (beat1_we && !keep)
				begin
					if (wr_lsb_reg)
					begin
						bank0[wr_row_reg] <= din;
					end
					else
					begin
						bank1[wr_row_reg] <= din;
					end
				end
			end

			// First word from the seeded array, second from the other
			assign rd_word0[lane*LANE_W +: LANE_W] = link.burst_start_lsb ?
				bank1[cmd_row] : bank0[cmd_row];
			assign rd_word1[lane*LANE_W +: LANE_W] = link.burst_start_lsb ?
				bank0[cmd_row] : bank1[cmd_row];
		end
	endgenerate

	// ************************************************************
	// Read pipeline, one slot per output clock edge
	// ************************************************************
	logic [PIPE_SLOTS-1:0] slot_v_reg;
	logic [PIPE_SLOTS-1:0][DATA_W-1:0] slot_data_reg;
	logic [PIPE_SLOTS-1:0] shift_v;
	logic [PIPE_SLOTS-1:0][DATA_W-1:0] shift_data;
	logic [1:0] first_slot;

	// Slot of beat 0 set by the latency mode
	assign first_slot = link.pll_disable_n ? SLOT_DDR2 : SLOT_LEGACY;
	assign shift_v = {1'b0, slot_v_reg[PIPE_SLOTS-1:1]};
	assign shift_data = {DATA_W'(0), slot_data_reg[PIPE_SLOTS-1:1]};

	// Load both beats of a read, advance on each output edge
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			slot_v_reg <= '0;
			slot_data_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < PIPE_SLOTS; i++)
			begin
				if (rd_go && i == int'(first_slot))
				begin
					slot_v_reg[i] <= 1'b1;
					slot_data_reg[i] <= rd_word0;
				end
				else if (rd_go && i == int'(first_slot) + 1)
				begin
					slot_v_reg[i] <= 1'b1;
					slot_data_reg[i] <= rd_word1;
				end
				else if (out_edge)
				begin
					slot_v_reg[i] <= shift_v[i];
					slot_data_reg[i] <= shift_data[i];
				end
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic [DATA_W-1:0] dq_out_reg;
	logic dq_oe_reg;
	logic echo_p_reg;
	logic echo_n_reg;
	logic single_reg;

	// Drive the due beat, release the bus otherwise
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			dq_out_reg <= '0;
			dq_oe_reg <= 1'b0;
		end
		else if (out_edge)
		begin
			dq_out_reg <= slot_data_reg[0];
			dq_oe_reg <= slot_v_reg[0];
		end
	end

	// Echo clocks track the chosen output clocks
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			echo_p_reg <= 1'b0;
			echo_n_reg <= 1'b1;
			single_reg <= 1'b0;
		end
		else
		begin
			echo_p_reg <= single_mode ? link.k_p : link.c_p;
			echo_n_reg <= single_mode ? link.k_n : link.c_n;
			single_reg <= single_mode;
		end
	end

	assign link.dev_dq_out = dq_out_reg;
	assign link.dev_dq_oe = dq_oe_reg;
	assign link.echo_clk_p = echo_p_reg;
	assign link.echo_clk_n = echo_n_reg;
	assign single_clock_mode_out = single_reg;

endmodule
`default_nettype wire

// *** src/sram_host_end.sv ***
// Purpose: Controller end: issues bursts, captures reads on echo clocks
// Assumes: One transaction at a time; link clocks divided from clk_in
// Notes: Read data returns through an eight-word FIFO
`timescale 1ns/1ps
`default_nettype none
module sram_host_end (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Link to the SRAM
	sram_link_if.host link,
	// Mode selection
	input wire logic pll_enable_in,
	input wire logic single_clock_in,
	// Requests
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [sram_port_pkg::ADDR_W-1:0] req_addr_in,
	input wire logic [sram_port_pkg::DATA_W-1:0] req_wdata0_in,
	input wire logic [sram_port_pkg::DATA_W-1:0] req_wdata1_in,
	input wire logic [sram_port_pkg::LANES-1:0] req_mask0_n_in,
	input wire logic [sram_port_pkg::LANES-1:0] req_mask1_n_in,
	output logic req_ready_out,
	// Read data
	output logic rd_valid_out,
	output logic [sram_port_pkg::DATA_W-1:0] rd_data_out,
	input wire logic rd_ready_in
);
	import sram_port_pkg::*;

	host_state_t state_reg;
	logic k_p_reg, k_n_reg, c_p_reg, c_n_reg;
	logic single_reg, pll_n_reg, ready_reg;
	logic ld_n_reg, rd_reg, lsb_reg, oe_reg;
	logic [ADDR_W-2:0] addr_reg;
	logic [LANES-1:0] mask_reg;
	logic [DATA_W-1:0] dq_reg;
	logic [DATA_W-1:0] wd1_reg;
	logic [LANES-1:0] m1_reg;
	logic ep_q, en_q, echo_edge, push, last;
	logic [2:0] ecnt_reg;
	logic [2:0] first_idx;
	logic [FIFO_LEVEL_W-1:0] level;
	logic fifo_in_ready;
	logic accept;

	// ************************************************************
	// Link clocks
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			k_p_reg <= 1'b0;
			k_n_reg <= 1'b1;
			c_p_reg <= 1'b0;
			c_n_reg <= 1'b1;
			single_reg <= 1'b0;
			pll_n_reg <= 1'b1;
		end
		else
		begin
			k_p_reg <= !k_p_reg;
			k_n_reg <= k_p_reg;
			c_p_reg <= single_reg ? 1'b1 : !k_p_reg;
			c_n_reg <= single_reg ? 1'b1 : k_p_reg;
			single_reg <= single_clock_in;
			pll_n_reg <= pll_enable_in;
		end
	end

	// ************************************************************
	// Echo capture
	// ************************************************************
	assign echo_edge = (link.echo_clk_p && !ep_q) ||
		(link.echo_clk_n && !en_q);
	assign first_idx = pll_n_reg ? ECHO_FIRST_DDR2 : ECHO_FIRST_LEGACY;
	assign push = (state_reg == H_RWAIT) && echo_edge &&
		(ecnt_reg == first_idx || ecnt_reg == first_idx + 3'h1);
	assign last = push && ecnt_reg != first_idx;
	assign accept = req_valid_in && ready_reg;

	// Previous echo levels
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			ep_q <= 1'b1;
			en_q <= 1'b1;
		end
		else
		begin
			ep_q <= link.echo_clk_p;
			en_q <= link.echo_clk_n;
		end
	end

	// ************************************************************
	// Transaction sequencing
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			state_reg <= H_IDLE;
			ld_n_reg <= 1'b1;
			rd_reg <= 1'b1;
			addr_reg <= '0;
			lsb_reg <= 1'b0;
			mask_reg <= MASK_IDLE;
			dq_reg <= '0;
			oe_reg <= 1'b0;
			wd1_reg <= '0;
			m1_reg <= MASK_IDLE;
			ecnt_reg <= '0;
			ready_reg <= 1'b0;
		end
		else
		begin
			// Offer a slot just before a K rise, with room for two words
			ready_reg <= state_reg == H_IDLE && k_p_reg &&
				level <= FIFO_ROOM_MAX && !ready_reg;
			case (state_reg)
				H_IDLE:
				begin
					if (accept)
					begin
						ld_n_reg <= 1'b0;
						rd_reg <= !req_write_in;
						addr_reg <= req_addr_in[ADDR_W-1:1];
						lsb_reg <= req_addr_in[0];
						dq_reg <= req_wdata0_in;
						mask_reg <= req_mask0_n_in;
						wd1_reg <= req_wdata1_in;
						m1_reg <= req_mask1_n_in;
						ready_reg <= 1'b0;
						state_reg <= H_CMD;
					end
				end
				H_CMD:
				begin
					ld_n_reg <= 1'b1;
					ecnt_reg <= '0;
					oe_reg <= !rd_reg;
					state_reg <= rd_reg ? H_RWAIT : H_WBEAT1;
				end
				H_WBEAT1:
				begin
					dq_reg <= wd1_reg;
					mask_reg <= m1_reg;
					state_reg <= H_WEND;
				end
				H_WEND:
				begin
					oe_reg <= 1'b0;
					mask_reg <= MASK_IDLE;
					state_reg <= H_IDLE;
				end
				H_RWAIT:
				begin
					if (echo_edge)
					begin
						ecnt_reg <= ecnt_reg + 3'h1;
					end
					if (last)
					begin
						state_reg <= H_IDLE;
					end
				end
				default:
				begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Read return buffer
	// ************************************************************
	word_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(push && fifo_in_ready),
		.in_data_in(link.dq),
		.in_ready_out(fifo_in_ready),
		.out_valid_out(rd_valid_out),
		.out_data_out(rd_data_out),
		.out_ready_in(rd_ready_in),
		.level_out(level)
	);

	assign link.k_p = k_p_reg;
	assign link.k_n = k_n_reg;
	assign link.c_p = c_p_reg;
	assign link.c_n = c_n_reg;
	assign link.cycle_load_n = ld_n_reg;
	assign link.rd_not_wr = rd_reg;
	assign link.addr_upper = addr_reg;
	assign link.burst_start_lsb = lsb_reg;
	assign link.byte_lane_mask_n = mask_reg;
	assign link.pll_disable_n = pll_n_reg;
	assign link.host_dq_out = dq_reg;
	assign link.host_dq_oe = oe_reg;
	assign req_ready_out = ready_reg;

endmodule
`default_nettype wire

// *** dv/sram_link_monitor.sv ***
// Purpose: Protocol checks on the SRAM link pins
// Assumes: All link pins change just after clk_in rises
// Notes: Latency windows use the mode seen with the command
`timescale 1ns/1ps
`default_nettype none
module sram_link_monitor (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Link pins
	input wire logic k_p,
	input wire logic k_n,
	input wire logic c_p,
	input wire logic c_n,
	input wire logic cycle_load_n,
	input wire logic rd_not_wr,
	input wire logic pll_disable_n,
	input wire logic host_dq_oe,
	input wire logic dev_dq_oe,
	input wire logic echo_clk_p,
	input wire logic echo_clk_n
);
	// ************************************************************
	// Command decode
	// ************************************************************
	logic k_p_reg;
	logic rd_cmd;
	logic wr_cmd;

	// Previous K level for rise detection
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			k_p_reg <= 1'b0;
		else
			k_p_reg <= k_p;
	end

	// Commands count only on a K rise
	assign rd_cmd = !cycle_load_n && rd_not_wr && k_p && !k_p_reg;
	assign wr_cmd = !cycle_load_n && !rd_not_wr && k_p && !k_p_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// Two driven beats, then release
	sequence burst_s(oe);
		oe [*2] ##1 !oe;
	endsequence

	a_write_beats: assert property (wr_cmd |=> burst_s(host_dq_oe))
		else $error("write beats not two cycles after command");
	a_lat_legacy: assert property (
		rd_cmd && !pll_disable_n |->
		##2 !dev_dq_oe ##1 burst_s(dev_dq_oe))
		else $error("legacy read beats misplaced");
	a_lat_ddr2: assert property (
		rd_cmd && pll_disable_n |->
		##3 !dev_dq_oe ##1 burst_s(dev_dq_oe))
		else $error("pll read beats misplaced");
	a_oe_after_read: assert property (dev_dq_oe |->
		$past(rd_cmd, 3) || $past(rd_cmd, 4) || $past(rd_cmd, 5))
		else $error("data driven without a read");
	a_no_contention: assert property (!(dev_dq_oe && host_dq_oe))
		else $error("both ends drive the data bus");
	a_load_krise: assert property (!cycle_load_n |-> k_p && !k_p_reg)
		else $error("load strobe off a K rise");
	a_load_single: assert property (!cycle_load_n |=> cycle_load_n [*3])
		else $error("load strobe held or repeated");
	a_echo_pair: assert property (echo_clk_n == !echo_clk_p)
		else $error("echo clocks not complementary");
	a_echo_follow: assert property (c_p != c_n |=>
		echo_clk_p == $past(c_p))
		else $error("echo clock does not follow C");
	a_echo_single: assert property (c_p && c_n |=>
		echo_clk_p == $past(k_p))
		else $error("echo clock does not follow K");
	a_echo_runs: assert property ($rose(echo_clk_p) |=> $fell(echo_clk_p))
		else $error("echo clock stopped");
endmodule
`default_nettype wire

// *** dv/tb_ddr2_burst2_sram_port.sv ***
// Purpose: Self-checking bench for both ends of the SRAM port
// Assumes: Inputs change on falling edges of clk_in
// Notes: Read data is judged at the controller FIFO output
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_burst2_sram_port;
	import sram_port_pkg::*;

	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic clk_in;
	logic rst_b_in;
	logic pll_enable_in;
	logic single_clock_in;
	logic req_valid_in;
	logic req_write_in;
	logic [ADDR_W-1:0] req_addr_in;
	logic [DATA_W-1:0] req_wdata0_in;
	logic [DATA_W-1:0] req_wdata1_in;
	logic [LANES-1:0] req_mask0_n_in;
	logic [LANES-1:0] req_mask1_n_in;
	logic req_ready_out;
	logic rd_valid_out;
	logic [DATA_W-1:0] rd_data_out;
	logic rd_ready_in;
	logic single_clock_mode_out;
	int fails;
	int total_checks;

	sram_link_if sram_link_if_i ();
	sram_device_end sram_device_end_i (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.link(sram_link_if_i.device),
		.single_clock_mode_out(single_clock_mode_out)
	);
	sram_host_end sram_host_end_i (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.link(sram_link_if_i.host),
		.pll_enable_in(pll_enable_in),
		.single_clock_in(single_clock_in),
		.req_valid_in(req_valid_in),
		.req_write_in(req_write_in),
		.req_addr_in(req_addr_in),
		.req_wdata0_in(req_wdata0_in),
		.req_wdata1_in(req_wdata1_in),
		.req_mask0_n_in(req_mask0_n_in),
		.req_mask1_n_in(req_mask1_n_in),
		.req_ready_out(req_ready_out),
		.rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out),
		.rd_ready_in(rd_ready_in)
	);
	sram_link_monitor sram_link_monitor_i (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.k_p(sram_link_if_i.k_p),
		.k_n(sram_link_if_i.k_n),
		.c_p(sram_link_if_i.c_p),
		.c_n(sram_link_if_i.c_n),
		.cycle_load_n(sram_link_if_i.cycle_load_n),
		.rd_not_wr(sram_link_if_i.rd_not_wr),
		.pll_disable_n(sram_link_if_i.pll_disable_n),
		.host_dq_oe(sram_link_if_i.host_dq_oe),
		.dev_dq_oe(sram_link_if_i.dev_dq_oe),
		.echo_clk_p(sram_link_if_i.echo_clk_p),
		.echo_clk_n(sram_link_if_i.echo_clk_n)
	);

	// 20 MHz system clock
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk_word(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Hold a request until taken or the wait runs out
	task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
		input logic [LANES-1:0] m0, input logic [LANES-1:0] m1,
		input logic exp);
		int n;
		logic taken;
		n = 0;
		taken = 1'b0;
		// Let an edge pass so valid never falls and rises in one step
		@(negedge clk_in);
		req_write_in = wr;
		req_addr_in = a;
		req_wdata0_in = d0;
		req_wdata1_in = d1;
		req_mask0_n_in = m0;
		req_mask1_n_in = m1;
		req_valid_in = 1'b1;
		// A pulse already up here is taken at the coming rise
		while (req_ready_out !== 1'b1 && n < 40)
		begin
			@(negedge clk_in);
			n++;
		end
		taken = (req_ready_out === 1'b1);
		@(negedge clk_in);
		req_valid_in = 1'b0;
		chk_bit("req_taken", exp, taken);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic exp);
		send(1'b0, a, 36'h000000000, 36'h000000000, MASK_IDLE, MASK_IDLE, exp);
	endtask

	// Wait for a read word, judge it, pop it
	task automatic pop(input logic [DATA_W-1:0] exp);
		int n;
		n = 0;
		// Keep ready low across one edge between pops
		@(negedge clk_in);
		while (rd_valid_out !== 1'b1 && n < 40)
		begin
			@(negedge clk_in);
			n++;
		end
		chk_bit("rd_valid", 1'b1, rd_valid_out);
		chk_word("rd_data", exp, rd_data_out);
		rd_ready_in = 1'b1;
		@(negedge clk_in);
		rd_ready_in = 1'b0;
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	// Full write then read of the same pair
	task automatic t_plain();
		send(1'b1, 21'h000010, 36'h123456789, 36'hABCDEF012, 4'h0, 4'h0,
			1'b1);
		rd(21'h000010, 1'b1);
		pop(36'h123456789);
		pop(36'hABCDEF012);
	endtask

	// Odd start address wraps within the pair
	task automatic t_odd();
		send(1'b1, 21'h000021, 36'h0F0F0F0F0, 36'h5A5A5A5A5, 4'h0, 4'h0,
			1'b1);
		rd(21'h000020, 1'b1);
		pop(36'h5A5A5A5A5);
		pop(36'h0F0F0F0F0);
	endtask

	// Masked lanes keep old contents
	task automatic t_mask();
		send(1'b1, 21'h000030, 36'hFFFFFFFFF, 36'hFFFFFFFFF, 4'h0, 4'h0,
			1'b1);
		send(1'b1, 21'h000030, 36'h000000000, 36'h000000000, 4'h5, 4'hA,
			1'b1);
		rd(21'h000030, 1'b1);
		pop(36'h007FC01FF);
		pop(36'hFF803FE00);
	endtask

	// Same traffic in PLL and single clock modes
	task automatic t_modes(input logic pll, input logic single);
		pll_enable_in = pll;
		single_clock_in = single;
		repeat (4) @(negedge clk_in);
		chk_bit("single_mode", single, single_clock_mode_out);
		send(1'b1, 21'h000040, 36'h111111111, 36'h222222222, 4'h0, 4'h0,
			1'b1);
		rd(21'h000041, 1'b1);
		pop(36'h222222222);
		pop(36'h111111111);
		pll_enable_in = 1'b0;
		single_clock_in = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask

	// Fill the read FIFO, see refusal, then drain
	task automatic t_fifo();
		rd(21'h000010, 1'b1);
		rd(21'h000020, 1'b1);
		rd(21'h000030, 1'b1);
		rd(21'h000010, 1'b1);
		rd(21'h000020, 1'b0);
		pop(36'h123456789);
		pop(36'hABCDEF012);
		pop(36'h5A5A5A5A5);
		pop(36'h0F0F0F0F0);
		pop(36'h007FC01FF);
		pop(36'hFF803FE00);
		pop(36'h123456789);
		pop(36'hABCDEF012);
		chk_bit("fifo_empty", 1'b0, rd_valid_out);
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial
	begin
		fails = 0;
		total_checks = 0;
		rst_b_in = 1'b0;
		pll_enable_in = 1'b0;
		single_clock_in = 1'b0;
		req_valid_in = 1'b0;
		req_write_in = 1'b0;
		req_addr_in = 21'h000000;
		req_wdata0_in = 36'h000000000;
		req_wdata1_in = 36'h000000000;
		req_mask0_n_in = MASK_IDLE;
		req_mask1_n_in = MASK_IDLE;
		rd_ready_in = 1'b0;
		repeat (8) @(negedge clk_in);
		rst_b_in = 1'b1;
		t_plain();
		t_odd();
		t_mask();
		t_modes(1'b1, 1'b0);
		t_modes(1'b0, 1'b1);
		t_fifo();
		report_and_stop();
	end

	// Cut a hang short
	initial
	begin
		repeat (5000) @(posedge clk_in);
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
